// ### uwh_link.sv
// radio-side serial link: 8N1 transmitter and receiver plus wake handshake
// assumes all inputs synchronous to clock; wakeN driven by the host only
`timescale 1ns/10ps
`include "uwh_consts.svh"

// Behaviour
// - two-wire mode: data lines only, no handshake
// - two-wire above 4800 bps disables sleep
// - three-wire: active-low wake input requests sending
// - on wake and ready, send 0x88 unless busy
// - full duplex; host sends after handshake
// - baud rate between 4800 and 250000 bps
module uwh_link
(
   // clock and reset
   input wire logic clock,
   input wire logic srst,
   // configuration
   input wire logic threeWireMode,
   input wire uwh_pkg::uwh_div_t baudDiv,
   input wire logic sleepRequest,
   input wire logic rxReady,
   // serial pins
   input wire logic radioSerialIn,
   output logic radioSerialOut,
   input wire logic wakeN,
   // user transmit side
   input wire uwh_pkg::uwh_byte_t txData,
   input wire logic txValid,
   output logic txReady,
   // user receive side
   output uwh_pkg::uwh_byte_t rxData,
   output logic rxValid,
   output logic rxFrameError,
   // status
   output logic sleepAllowed,
   output logic baudInRange,
   output logic ackSent
);
   import uwh_pkg::*;

   //**********************************************
   // configuration and handshake
   //**********************************************
   uwh_tx_t txState_ff;
   uwh_rx_t rxState_ff;
   uwh_byte_t txShift_ff;
   uwh_byte_t rxShift_ff;
   uwh_byte_t rxData_ff;
   uwh_div_t txTimer_ff;
   uwh_div_t rxTimer_ff;
   logic [2:0] txBit_ff;
   logic [2:0] rxBit_ff;
   logic txOut_ff;
   logic rxValid_ff;
   logic rxErr_ff;
   logic sleep_ff;
   logic wakePrev_ff;
   logic ackPending_ff;
   logic ackSent_ff;
   logic ackStart;
   logic txLoad;
   logic txTick;
   logic rxTick;
   logic fastRate;

   // legal divisor window
   assign baudInRange = (baudDiv >= `UWH_DIV_MIN) &&
                        (baudDiv <= `UWH_DIV_SLOW);
   assign fastRate = baudDiv < `UWH_DIV_SLOW;

   // sleep permission
   always_ff @(posedge clock)
   begin
      if (srst)
         sleep_ff <= 1'b0;
      else
         sleep_ff <= sleepRequest && !(!threeWireMode && fastRate);
   end

   // ack owed after a wake request; set wins over clear
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         wakePrev_ff <= `UWH_IDLE_LEVEL;
         ackPending_ff <= 1'b0;
      end
      else
      begin
         wakePrev_ff <= wakeN;
         if (threeWireMode && wakePrev_ff && !wakeN)
            ackPending_ff <= 1'b1;
         else if (!threeWireMode || wakeN || ackStart || txLoad)
            ackPending_ff <= 1'b0;
      end
   end

   // ack goes only when idle with no packet byte offered
   assign ackStart = threeWireMode && ackPending_ff && rxReady && !wakeN &&
                     txState_ff == TX_IDLE && !txValid && baudInRange;
   assign txReady = (txState_ff == TX_IDLE) && baudInRange;
   assign txLoad = txValid && txReady;

   //**********************************************
   // transmitter
   //**********************************************
   assign txTick = (txTimer_ff == 16'h0000);

   // transmit bit timer
   always_ff @(posedge clock)
   begin
      if (srst || txState_ff == TX_IDLE || txTick)
         txTimer_ff <= baudDiv - 16'h0001;
      else
         txTimer_ff <= txTimer_ff - 16'h0001;
   end

   // transmit framing: start, 8 data lsb first, stop
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         txState_ff <= TX_IDLE;
         txShift_ff <= 8'h00;
         txBit_ff <= 3'h0;
         txOut_ff <= `UWH_IDLE_LEVEL;
      end
      else
      begin
         unique case (txState_ff)
            TX_IDLE:
            begin
               txOut_ff <= `UWH_IDLE_LEVEL;
               if (ackStart || txLoad)
               begin
                  txShift_ff <= ackStart ? `UWH_ACK_BYTE : txData;
                  txState_ff <= TX_START;
                  txOut_ff <= 1'b0;
               end
            end
            TX_START:
               if (txTick)
               begin
                  txState_ff <= TX_DATA;
                  txBit_ff <= 3'h0;
                  txOut_ff <= txShift_ff[0];
               end
            TX_DATA:
               if (txTick)
               begin
                  if (txBit_ff == `UWH_LAST_BIT)
                  begin
                     txState_ff <= TX_STOP;
                     txOut_ff <= 1'b1;
                  end
                  else
                  begin
                     txBit_ff <= txBit_ff + 3'h1;
                     txOut_ff <= txShift_ff[txBit_ff + 3'h1];
                  end
               end
            TX_STOP:
               if (txTick)
                  txState_ff <= TX_IDLE;
         endcase
      end
   end

   // ack-sent pulse
   always_ff @(posedge clock)
   begin
      if (srst)
         ackSent_ff <= 1'b0;
      else
         ackSent_ff <= ackStart;
   end

   //**********************************************
   // receiver, independent of the transmitter
   //**********************************************
   assign rxTick = (rxTimer_ff == 16'h0000);

   // receive bit timer; half a bit first to hit mid-bit
   always_ff @(posedge clock)
   begin
      if (srst || (rxState_ff == RX_IDLE && radioSerialIn))
         rxTimer_ff <= {1'b0, baudDiv[15:1]};
      else if (rxTick)
         rxTimer_ff <= baudDiv - 16'h0001;
      else
         rxTimer_ff <= rxTimer_ff - 16'h0001;
   end

   // receive framing, one byte at a time; any chunking is above us
   always_ff @(posedge clock)
   begin
      if (srst)
      begin
         rxState_ff <= RX_IDLE;
         rxShift_ff <= 8'h00;
         rxData_ff <= 8'h00;
         rxBit_ff <= 3'h0;
         rxValid_ff <= 1'b0;
         rxErr_ff <= 1'b0;
      end
      else
      begin
         rxValid_ff <= 1'b0;
         rxErr_ff <= 1'b0;
         unique case (rxState_ff)
            RX_IDLE:
               if (!radioSerialIn && baudInRange)
                  rxState_ff <= RX_START;
            RX_START:
               if (rxTick)
               begin
                  rxBit_ff <= 3'h0;
                  rxState_ff <= radioSerialIn ? RX_IDLE : RX_DATA;
               end
            RX_DATA:
               if (rxTick)
               begin
                  rxShift_ff <= {radioSerialIn, rxShift_ff[7:1]};
                  rxBit_ff <= rxBit_ff + 3'h1;
                  if (rxBit_ff == `UWH_LAST_BIT)
                     rxState_ff <= RX_STOP;
               end
            RX_STOP:
               if (rxTick)
               begin
                  rxState_ff <= RX_IDLE;
                  rxData_ff <= rxShift_ff;
                  rxValid_ff <= radioSerialIn;
                  rxErr_ff <= !radioSerialIn;
               end
         endcase
      end
   end

   // outputs
   assign radioSerialOut = txOut_ff;
   assign rxData = rxData_ff;
   assign rxValid = rxValid_ff;
   assign rxFrameError = rxErr_ff;
   assign sleepAllowed = sleep_ff;
   assign ackSent = ackSent_ff;

   //**********************************************
   // checks
   //**********************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   sequence s_ack_go;
      ackStart;
   endsequence
   sequence s_start_bit;
      txState_ff == TX_START && !radioSerialOut && txShift_ff == `UWH_ACK_BYTE;
   endsequence

   a_two_wire_quiet: assert property (!threeWireMode |-> !ackStart)
      else $error("ack sent in two-wire mode");
   a_sleep_fast_off: assert property
      (!threeWireMode && fastRate |=> !sleepAllowed)
      else $error("sleep allowed at fast two-wire rate");
   a_wake_sets_ack: assert property
      (threeWireMode && $fell(wakeN) |=> ackPending_ff)
      else $error("wake request not registered");
   a_ack_byte_out: assert property (s_ack_go |=> s_start_bit)
      else $error("ack did not start with 0x88");
   a_ack_not_busy: assert property
      (ackStart |-> !txValid && $past(txState_ff) != TX_DATA)
      else $error("ack sent while packet data busy");
   a_ack_once_only: assert property (ackStart |=> !ackPending_ff ##1 !ackSent)
      else $error("ack repeated");
   a_stop_high: assert property (txState_ff == TX_STOP |-> radioSerialOut)
      else $error("stop bit not high");
   a_rate_gate: assert property (!baudInRange |-> !txReady && !ackStart)
      else $error("transmit at illegal rate");
endmodule

// ### uwh_consts.svh
// constants for the wake-handshake serial link
// assumes a 100 MHz system clock
`ifndef UWH_CONSTS_SVH
`define UWH_CONSTS_SVH
`define UWH_ACK_BYTE 8'h88
`define UWH_CLK_HZ 100000000
`define UWH_BAUD_MIN_BPS 4800
`define UWH_BAUD_MAX_BPS 250000
`define UWH_DIV_W 16
// fewest clocks per bit (fastest rate), rounded up
`define UWH_DIV_MIN 16'(((`UWH_CLK_HZ)+(`UWH_BAUD_MAX_BPS)-1)/(`UWH_BAUD_MAX_BPS))
// clocks per bit at the slowest rate, rounded up; below it rate > 4800 bps
`define UWH_DIV_SLOW 16'(((`UWH_CLK_HZ)+(`UWH_BAUD_MIN_BPS)-1)/(`UWH_BAUD_MIN_BPS))
`define UWH_LAST_BIT 3'h7
`define UWH_IDLE_LEVEL 1'b1
`endif

// ### uwh_pkg.sv
// types for the wake-handshake serial link
// used by uwh_link, uwh_host_model and tb
package uwh_pkg;
   typedef logic [7:0] uwh_byte_t;
   typedef logic [15:0] uwh_div_t;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} uwh_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uwh_rx_t;
endpackage

// ### uwh_host_model.sv
// application-side serial driver model: 8N1 line and wake handshake
// assumes div equals the design's clocks per bit
`timescale 1ns/10ps
module uwh_host_model
#(
   parameter int TIMEOUT_CYC = 500000
)
(
   // clock and rate
   input wire logic clock,
   input wire uwh_pkg::uwh_div_t div,
   // serial pins
   output logic radioSerialIn,
   input wire logic radioSerialOut,
   output logic wakeN
);
   import uwh_pkg::*;
   // lines idle high, wake released
   initial
   begin
      radioSerialIn = 1'b1;
      wakeN = 1'b1;
   end
   // one character, lsb first; a low stop makes a framing fault
   task automatic send_byte(input uwh_byte_t b, input logic stopBit);
      logic [9:0] fr;
      fr = {stopBit, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clock);
         radioSerialIn <= fr[i];
         repeat (div - 1) @(posedge clock);
      end
      @(posedge clock);
      radioSerialIn <= 1'b1;
   endtask
   // wait up to limit cycles for a start bit, sample at mid-bit
   task automatic get_byte(input int limit, output uwh_byte_t b,
                           output bit ok);
      int n;
      n = 0;
      b = '0;
      while (radioSerialOut !== 1'b0 && n < limit)
      begin
         @(posedge clock);
         n++;
      end
      ok = (n < limit);
      if (ok)
      begin
         repeat (div / 2) @(posedge clock);
         for (int i = 0; i < 8; i++)
         begin
            repeat (div) @(posedge clock);
            b[i] = radioSerialOut;
         end
         repeat (div) @(posedge clock);
      end
   endtask
   // request, wait for a reply, release, then send the packet
   task automatic send_packet(input uwh_byte_t pkt[$],
                              output uwh_byte_t ack, output int tries);
      bit ok;
      tries = 0;
      ok = 0;
      while (!ok && tries < 4)
      begin
         @(posedge clock);
         wakeN <= 1'b0;
         tries++;
         get_byte(TIMEOUT_CYC, ack, ok);
         @(posedge clock);
         wakeN <= 1'b1;
      end
      foreach (pkt[i]) send_byte(pkt[i], 1'b1);
   endtask
endmodule

// ### tb.sv
// self-checking bench for the radio-side wake-handshake link
// assumes uwh_link and uwh_host_model are compiled first
`timescale 1ns/10ps
`include "uwh_consts.svh"
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin \
   bad_count++; $display("MISMATCH %s exp %0h got %0h", nm, e, a); end end
module tb;
   import uwh_pkg::*;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic threeWireMode = 1'b0;
   uwh_div_t baudDiv = 16'h0190;
   logic sleepRequest = 1'b1;
   logic rxReady = 1'b1;
   logic txValid = 1'b0;
   uwh_byte_t txData = 8'h00;
   logic radioSerialIn, radioSerialOut, wakeN, txReady, rxValid;
   logic rxFrameError, sleepAllowed, baudInRange, ackSent, eE, eR;
   uwh_byte_t rxData, eB, ackB, b;
   uwh_byte_t expQ[$], pkt[$];
   logic errQ[$];
   uwh_div_t divs[4] = '{16'h018F, 16'h0190, 16'h5162, 16'h5163};
   int bad_count = 0;
   int num_checks = 0;
   int ackCnt = 0;
   int tries;
   bit ok;
   uwh_link u_dut (.clock(clock), .srst(srst), .threeWireMode(threeWireMode),
      .baudDiv(baudDiv), .sleepRequest(sleepRequest), .rxReady(rxReady),
      .radioSerialIn(radioSerialIn), .radioSerialOut(radioSerialOut),
      .wakeN(wakeN), .txData(txData), .txValid(txValid), .txReady(txReady),
      .rxData(rxData), .rxValid(rxValid), .rxFrameError(rxFrameError),
      .sleepAllowed(sleepAllowed), .baudInRange(baudInRange),
      .ackSent(ackSent));
   uwh_host_model #(.TIMEOUT_CYC(3000)) u_host (.clock(clock),
      .div(baudDiv), .radioSerialIn(radioSerialIn),
      .radioSerialOut(radioSerialOut), .wakeN(wakeN));
   always #5 clock = ~clock;
   // reference receiver: each delivered byte pops the expected queue
   always @(posedge clock)
   begin
      if (ackSent === 1'b1) ackCnt++;
      if (rxValid === 1'b1 || rxFrameError === 1'b1)
      begin
         eB = expQ.pop_front();
         eE = errQ.pop_front();
         `CHK("rxData", eB, rxData)
         `CHK("rxFrameError", eE, rxFrameError)
      end
   end
   // offer one byte and hold it until taken
   task automatic tx_byte(input uwh_byte_t v);
      @(posedge clock);
      txData <= v;
      txValid <= 1'b1;
      @(posedge clock);
      for (int n = 0; n < 20000 && txReady !== 1'b1; n++) @(posedge clock);
      // a byte never taken counts against the run
      `CHK("txTaken", 1'b1, txReady)
      txValid <= 1'b0;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // watchdog: the tests need about 49000 cycles
   initial
   begin
      #1000000;
      bad_count++;
      print_verdict();
   end
   // main sequence
   initial
   begin
      void'($urandom(32'hDA761B9A));
      repeat (12) @(posedge clock);
      `CHK("idleOut", 1'b1, radioSerialOut)
      srst <= 1'b0;
      foreach (divs[i])
      begin
         @(posedge clock);
         baudDiv <= divs[i];
         repeat (2) @(posedge clock);
         // legal window has both a lower and an upper divisor bound
         eR = (divs[i] >= `UWH_DIV_MIN) && (divs[i] <= `UWH_DIV_SLOW);
         `CHK("inRange", eR, baudInRange)
         `CHK("sleep", (divs[i] >= `UWH_DIV_SLOW), sleepAllowed)
      end
      `CHK("txReady", 1'b0, txReady)
      baudDiv <= 16'h0190;
      pkt = '{8'($urandom), 8'($urandom)};
      fork
         foreach (pkt[i]) tx_byte(pkt[i]);
         for (int i = 0; i < 2; i++)
         begin
            u_host.get_byte(10000, b, ok);
            `CHK("hostOk", 1'b1, ok)
            `CHK("hostRx", pkt[i], b)
         end
      join
      b = 8'($urandom);
      expQ = '{b, ~b, b};
      errQ = '{1'b0, 1'b1, 1'b0};
      u_host.send_byte(b, 1'b1);
      u_host.send_byte(~b, 1'b0);
      pkt = '{b};
      u_host.send_packet(pkt, ackB, tries);
      `CHK("noAck", 0, ackCnt)
      threeWireMode <= 1'b1;
      rxReady <= 1'b0;
      pkt = '{8'($urandom), 8'($urandom)};
      foreach (pkt[i]) expQ.push_back(pkt[i]);
      errQ = '{1'b0, 1'b0};
      fork
         u_host.send_packet(pkt, ackB, tries);
         begin
            repeat (4000) @(posedge clock);
            rxReady <= 1'b1;
         end
      join
      `CHK("ackByte", `UWH_ACK_BYTE, ackB)
      `CHK("tries", 2, tries)
      `CHK("ackCount", 1, ackCnt)
      `CHK("sleep3", 1'b1, sleepAllowed)
      // firmware withdraws its sleep wish: permission must drop
      sleepRequest <= 1'b0;
      repeat (1000) @(posedge clock);
      `CHK("sleepOff", 1'b0, sleepAllowed)
      `CHK("left", 0, expQ.size())
      print_verdict();
   end
endmodule
